// File: pkg/cma_pkg.sv
// Shared constants for the configuration-mode access link:
// port addresses, keys, register defaults and state encodings.
// Assumes an 8-bit I/O data path with one-cycle strobes.
package cma_pkg;

  localparam logic [15:0] IDX_PORT  = 16'h03F0;
  localparam logic [15:0] DATA_PORT = 16'h03F1;

  localparam logic [7:0] KEY_STD  = 8'h55;
  localparam logic [7:0] KEY_ALT  = 8'h44;
  localparam logic [7:0] EXIT_KEY = 8'hAA;

  localparam int NUM_CFG = 16;

  localparam logic [3:0] LOCK_REG   = 4'h1;
  localparam int         LOCK_BIT   = 7;
  localparam logic [3:0] IDX_DEV_ID = 4'hD;
  localparam logic [3:0] IDX_REV_ID = 4'hE;

  // Registers 0..10 hold software state; B, C, F read zero
  localparam logic [15:0] CFG_WR_MASK = 16'h07FF;

  // Power-up defaults, entry 15 first
  localparam logic [15:0][7:0] CFG_DEFAULTS = {
    8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'h00,
    8'h78, 8'hDC, 8'h9F, 8'h3B
  };

  typedef enum logic [2:0] {
    DV_IDLE  = 3'b001,
    DV_ARMED = 3'b010,
    DV_CFG   = 3'b100
  } cma_dev_mode_t;

  // Host command register layout
  localparam logic [3:0] AV_CMD    = 4'h0;
  localparam logic [3:0] AV_STATUS = 4'h4;
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_IDX_LSB  = 8;
  localparam int CMD_DATA_LSB = 16;

  localparam logic [1:0] OP_ENTER = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_EXIT  = 2'h3;

  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CFG_BIT  = 1;
  localparam int ST_ERR_BIT  = 2;
  localparam int ST_RD_LSB   = 8;

  typedef enum logic [4:0] {
    HS_IDLE   = 5'b00001,
    HS_KEY2   = 5'b00010,
    HS_DATA   = 5'b00100,
    HS_RDREQ  = 5'b01000,
    HS_RDWAIT = 5'b10000
  } cma_host_state_t;

endpackage

// File: pkg/cma_bus_if.sv
// I/O bus between the configuration host and the device.
// Strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/1ns
`default_nettype none

interface cma_bus_if (
  input wire logic clk
);
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_rdata;
  logic        io_rack;

  modport device (
    input  clk,
    input  io_addr,
    input  io_wdata,
    input  io_wr,
    input  io_rd,
    output io_rdata,
    output io_rack
  );

  modport host (
    input  clk,
    output io_addr,
    output io_wdata,
    output io_wr,
    output io_rd,
    input  io_rdata,
    input  io_rack
  );
endinterface

`default_nettype wire

// File: design/cma_dev_end.sv
// Device end: key-unlocked configuration space of sixteen
// 8-bit registers behind an index port and a data port.
// Assumes one bus master; strobes sampled on rising clk.
// Both resets are synchronous; power-up outranks hard reset.
//
// Summary of operation
// [RL1] Two back-to-back key writes enter mode
// [RL2] Other write between keys discards sequence
// [RL3] Host masks interrupts during key writes
// [RL4] Index port selects register, data port accesses
// [RL5] Exit key leaves mode, registers unreachable
// [RL6] Enter, configure, exit in strict order
// [RL7] Index register plus sixteen indexed registers
// [RL8] Power-up loads documented register defaults
// [RL9] Variant uses alternate unlock key
// [RL10] Hard reset keeps register contents; here it also sets the lock bit in register 1
// [RL11] Cleared lock bit blocks all access; here it blocks data port only, index and exit writes still act
// [RL12] Outside mode, no configuration access
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none

module cma_dev_end
  import cma_pkg::*;
#(
  parameter logic [7:0] UNLOCK_KEY = KEY_STD,
  // Identity values are arbitrary
  parameter logic [7:0] DEV_IDENT  = 8'h5A,
  parameter logic [7:0] REV_IDENT  = 8'h03
) (
  input  wire logic                   clk,
  input  wire logic                   por_n,
  input  wire logic                   reset_n,
  cma_bus_if.device                   bus,
  output logic [NUM_CFG*8-1:0]        cfg_regs,
  output logic                        cfg_active,
  output logic                        cfg_open,
  output logic [3:0]                  cfg_index,
  output logic                        key_abort,
  output logic                        access_refused
);

  typedef struct packed {
    cma_dev_mode_t     mode;
    logic [3:0]        index;
    logic [15:0][7:0]  regs;
    logic [7:0]        rdata;
    logic              rack;
    logic              abort;
    logic              refused;
    // Port flags held as flops, not decoded from mode
    logic              active;
    logic              unlocked;
  } cma_dev_st_t;

  localparam cma_dev_st_t DEV_RESET = '{
    mode:    DV_IDLE,
    index:   4'h0,
    regs:    CFG_DEFAULTS,
    rdata:   8'h00,
    rack:    1'b0,
    abort:   1'b0,
    refused: 1'b0,
    active:  1'b0,
    unlocked: 1'b0
  };

  cma_dev_st_t st;
  cma_dev_st_t next_st;

  logic              hit_idx;
  logic              hit_dat;
  logic              is_key;
  logic              is_exit;
  logic              idx_valid;
  logic              space_open;
  logic              lock_set;
  logic [15:0]       wr_sel;
  logic [15:0][7:0]  rd_view;

  assign hit_idx   = bus.io_addr == IDX_PORT;
  assign hit_dat   = bus.io_addr == DATA_PORT;
  assign is_key    = bus.io_wdata == UNLOCK_KEY; // [RL9]
  assign is_exit   = bus.io_wdata == EXIT_KEY;
  assign idx_valid = bus.io_wdata[7:4] == 4'h0;

  // Lock bit lives in register 1 itself
  assign lock_set   = st.regs[LOCK_REG][LOCK_BIT];
  assign space_open = (st.mode == DV_CFG) && lock_set; // [RL11] [RL12]

  // Per-register write select and read view
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++) begin : g_reg
      localparam logic [3:0] IDX = 4'(gi);
      assign wr_sel[gi] = bus.io_wr && hit_dat && space_open
                          && (st.index == IDX) && CFG_WR_MASK[gi]; // [RL4]
      if (gi == int'(IDX_DEV_ID)) begin : g_dev
        assign rd_view[gi] = DEV_IDENT;
      end else if (gi == int'(IDX_REV_ID)) begin : g_rev
        assign rd_view[gi] = REV_IDENT;
      end else if (CFG_WR_MASK[gi]) begin : g_rw
        assign rd_view[gi] = st.regs[gi];
      end else begin : g_rsvd
        assign rd_view[gi] = 8'h00;
      end
    end
  endgenerate

  always_comb begin
    next_st         = st;
    next_st.rack    = 1'b0;
    next_st.rdata   = 8'h00;
    next_st.abort   = 1'b0;
    next_st.refused = 1'b0;

    if (bus.io_wr) begin
      case (st.mode)
        DV_IDLE: begin
          if (hit_idx && is_key) begin
            next_st.mode = DV_ARMED; // [RL1]
          end
        end
        DV_ARMED: begin
          // Reads between the keys keep the pair
          if (hit_idx && is_key) begin
            next_st.mode = DV_CFG; // [RL1] [RL6]
          end else begin
            // Any other write breaks the pair
            next_st.mode  = DV_IDLE; // [RL2]
            next_st.abort = 1'b1; // [RL2]
          end
        end
        DV_CFG: begin
          // Index values 10..FF other than exit are dropped
          if (hit_idx) begin
            if (is_exit) begin
              next_st.mode = DV_IDLE; // [RL5]
            end else if (idx_valid) begin
              next_st.index = bus.io_wdata[3:0]; // [RL4] [RL7]
            end
          end
          if (hit_dat && !space_open) begin
            next_st.refused = 1'b1; // [RL11]
          end
        end
        default: begin
          next_st.mode = DV_IDLE;
        end
      endcase
    end

    // Mask keeps reserved and ident entries untouched
    for (int i = 0; i < NUM_CFG; i++) begin
      if (wr_sel[i]) begin
        next_st.regs[i] = bus.io_wdata; // [RL4]
      end
    end

    // Index port is write-only and reads back zero
    if (bus.io_rd && (hit_idx || hit_dat)) begin
      next_st.rack = 1'b1;
      // Closed or locked data port answers with zero
      if (hit_dat && space_open) begin
        next_st.rdata = rd_view[st.index]; // [RL4]
      end else if (hit_dat && st.mode == DV_CFG) begin
        next_st.refused = 1'b1; // [RL11]
      end
    end

    // Hard reset leaves contents, only sets the lock bit again
    if (!reset_n) begin
      next_st.mode                     = DV_IDLE;
      next_st.index                    = 4'h0;
      next_st.rack                     = 1'b0;
      next_st.rdata                    = 8'h00;
      next_st.abort                    = 1'b0;
      next_st.refused                  = 1'b0;
      next_st.regs[LOCK_REG][LOCK_BIT] = 1'b1; // [RL10] [RL11]
    end

    // Power-up reset outranks everything above
    if (!por_n) begin
      next_st = DEV_RESET; // [RL8]
    end

    // Taken from the next state, so the flags carry no extra lag
    next_st.active   = next_st.mode == DV_CFG;
    next_st.unlocked = next_st.active && next_st.regs[LOCK_REG][LOCK_BIT]; // [RL11]
  end

  // One clocked process; both resets act through next_st
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Every port is a flop of st
  assign bus.io_rdata    = st.rdata;
  assign bus.io_rack     = st.rack;
  assign cfg_regs        = st.regs;
  assign cfg_active      = st.active;
  assign cfg_open        = st.unlocked;
  assign cfg_index       = st.index;
  assign key_abort       = st.abort;
  assign access_refused  = st.refused;

endmodule // cma_dev_end

`default_nettype wire

// File: design/cma_host_end.sv
// Host end: turns software commands on an Avalon-MM slave
// into key, index and data cycles on the I/O bus.
// Assumes it is the only master on the I/O bus.
`timescale 1ns/1ns
`default_nettype none

module cma_host_end
  import cma_pkg::*;
#(
  parameter logic [7:0] UNLOCK_KEY = KEY_STD
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  cma_bus_if.host           bus
);

  typedef struct packed {
    cma_host_state_t  fsm;
    logic [3:0]       idx;
    logic [7:0]       data;
    logic             in_cfg;
    logic             err;
    logic [7:0]       last_rd;
    logic             wreq;
    logic [31:0]      rdata;
    logic [15:0]      io_addr;
    logic [7:0]       io_wdata;
    logic             io_wr;
    logic             io_rd;
  } cma_host_st_t;

  localparam cma_host_st_t HOST_RESET = '{
    fsm: HS_IDLE, idx: 4'h0, data: 8'h00, in_cfg: 1'b0,
    err: 1'b0, last_rd: 8'h00, wreq: 1'b1, rdata: 32'h0,
    io_addr: 16'h0000, io_wdata: 8'h00, io_wr: 1'b0, io_rd: 1'b0
  };

  cma_host_st_t st;
  cma_host_st_t next_st;

  logic        busy;
  logic        take;
  logic [1:0]  op;
  logic [31:0] status;

  assign busy = st.fsm != HS_IDLE;
  assign op   = avs_writedata[CMD_OP_LSB +: 2];
  assign take = avs_write && !st.wreq && avs_address == AV_CMD;

  always_comb begin
    status                 = 32'h0;
    status[ST_BUSY_BIT]    = busy;
    status[ST_CFG_BIT]     = st.in_cfg;
    status[ST_ERR_BIT]     = st.err;
    status[ST_RD_LSB +: 8] = st.last_rd;
  end

  always_comb begin
    next_st       = st;
    next_st.wreq  = 1'b1;
    next_st.io_wr = 1'b0;
    next_st.io_rd = 1'b0;

    // Reads answer any time; writes wait for an idle sequencer
    if (st.wreq && avs_read) begin
      next_st.wreq  = 1'b0;
      next_st.rdata = (avs_address == AV_STATUS) ? status : 32'h0;
    end else if (st.wreq && avs_write && !busy) begin
      next_st.wreq = 1'b0;
    end

    case (st.fsm)
      HS_IDLE: begin
        if (take) begin
          next_st.idx      = avs_writedata[CMD_IDX_LSB +: 4];
          next_st.data     = avs_writedata[CMD_DATA_LSB +: 8];
          next_st.err      = 1'b0;
          next_st.io_addr  = IDX_PORT;
          next_st.io_wdata = {4'h0, avs_writedata[CMD_IDX_LSB +: 4]};
          case (op)
            OP_ENTER: begin
              next_st.io_wdata = UNLOCK_KEY; // [RL1] [RL9]
              next_st.io_wr    = 1'b1;
              next_st.fsm      = HS_KEY2;
            end
            OP_EXIT: begin
              next_st.io_wdata = EXIT_KEY; // [RL5]
              next_st.io_wr    = 1'b1;
              next_st.in_cfg   = 1'b0;
            end
            default: begin
              // Register access only between enter and exit
              if (st.in_cfg) begin
                next_st.io_wr = 1'b1; // [RL4] [RL6]
                next_st.fsm   = (op == OP_WRITE) ? HS_DATA : HS_RDREQ;
              end else begin
                next_st.err = 1'b1; // [RL6]
              end
            end
          endcase
        end
      end
      HS_KEY2: begin
        // Nothing may slip between the two keys
        next_st.io_addr  = IDX_PORT;
        next_st.io_wdata = UNLOCK_KEY; // [RL1] [RL3]
        next_st.io_wr    = 1'b1;
        next_st.in_cfg   = 1'b1;
        next_st.fsm      = HS_IDLE;
      end
      HS_DATA: begin
        next_st.io_addr  = DATA_PORT;
        next_st.io_wdata = st.data; // [RL4]
        next_st.io_wr    = 1'b1;
        next_st.fsm      = HS_IDLE;
      end
      HS_RDREQ: begin
        next_st.io_addr = DATA_PORT;
        next_st.io_rd   = 1'b1; // [RL4]
        next_st.fsm     = HS_RDWAIT;
      end
      HS_RDWAIT: begin
        if (bus.io_rack) begin
          next_st.last_rd = bus.io_rdata;
          next_st.fsm     = HS_IDLE;
        end
      end
      default: begin
        next_st.fsm = HS_IDLE;
      end
    endcase

    if (!reset_n) begin
      next_st = HOST_RESET;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = st.wreq;
  assign bus.io_addr     = st.io_addr;
  assign bus.io_wdata    = st.io_wdata;
  assign bus.io_wr       = st.io_wr;
  assign bus.io_rd       = st.io_rd;

endmodule // cma_host_end

`default_nettype wire

// File: bench/cma_props.sv
// Checker for the I/O bus that joins host end and device end.
// Assumes one clock and the host reset as the disable condition.
`timescale 1ns/1ns
`default_nettype none

module cma_props
  import cma_pkg::*;
#(
  parameter logic [7:0] KEY = KEY_STD
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic key_wr = io_wr && io_addr == IDX_PORT && io_wdata == KEY;
  sequence s_idx;
    io_wr && io_addr == IDX_PORT && io_wdata < 8'h10;
  endsequence
  sequence s_data;
    (io_wr || io_rd) && io_addr == DATA_PORT;
  endsequence
  property p_key;
    key_wr && !$past(key_wr) |=> key_wr ##1 !io_wr;
  endproperty
  a_key: assert property (p_key) else $error("key pair broken");
  property p_idx;
    s_idx |=> s_data;
  endproperty
  a_idx: assert property (p_idx) else $error("index not followed by data");
  property p_exit;
    io_wr && io_addr == IDX_PORT && io_wdata == EXIT_KEY |=> !io_wr && !io_rd;
  endproperty
  a_exit: assert property (p_exit) else $error("cycle after exit key");
  property p_rd_answer;
    io_rd && (io_addr == IDX_PORT || io_addr == DATA_PORT) |=> io_rack ##1 !io_rack;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer wrong");
  property p_rack_cause;
    io_rack |-> $past(io_rd);
  endproperty
  a_rack_cause: assert property (p_rack_cause) else $error("answer without read");
  property p_rdata_quiet;
    !io_rack |-> io_rdata == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside answer");
  property p_excl;
    !(io_wr && io_rd);
  endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_rd_after_idx;
    io_rd |-> $past(io_wr && io_addr == IDX_PORT);
  endproperty
  a_rd_after_idx: assert property (p_rd_after_idx) else $error("read without index");
endmodule // cma_props

`default_nettype wire

// File: bench/config_mode_register_access_tb.sv
// Bench: Avalon commands through host end to device end; a second
// device with the alternate key is driven directly on its own bus.
`timescale 1ns/1ns
`default_nettype none

module config_mode_register_access_tb;
  import cma_pkg::*;
  localparam logic [7:0] DEV_ID = 8'h5A; // Arbitrary
  localparam logic [7:0] REV_ID = 8'h03; // Arbitrary
  logic clk = 0, rst_n = 0, hrst_n = 0, por_n = 0;
  logic [3:0] avs_address = 0;
  logic avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [31:0] avs_writedata = 0, avs_readdata, rd, rnd = 32'h205A9FE8;
  logic [63:0] q[$];
  logic [63:0] e;
  logic [7:0] mem [16];
  logic act2, open2, abort2, ref2;
  logic [3:0] idx2;
  logic [127:0] regs2;
  int fail_count = 0, comparisons = 0;
  int n_abort = 0, n_ref = 0;
  cma_bus_if io (.clk(clk));
  cma_bus_if b2 (.clk(clk));
  cma_host_end i_cma_host_end (.clk(clk), .reset_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus(io));
  cma_dev_end #(.DEV_IDENT(DEV_ID), .REV_IDENT(REV_ID)) i_cma_dev_end (.clk(clk), .por_n(por_n),
    .reset_n(hrst_n), .bus(io), .cfg_regs(), .cfg_active(), .cfg_open(), .cfg_index(), .key_abort(),
    .access_refused());
  cma_dev_end #(.UNLOCK_KEY(KEY_ALT)) i_cma_dev_end_alt (.clk(clk), .por_n(por_n), .reset_n(hrst_n), .bus(b2),
    .cfg_regs(regs2), .cfg_active(act2), .cfg_open(open2), .cfg_index(idx2), .key_abort(abort2),
    .access_refused(ref2));
  cma_props i_cma_props (.clk(clk), .reset_n(rst_n), .io_addr(io.io_addr), .io_wdata(io.io_wdata),
    .io_wr(io.io_wr), .io_rd(io.io_rd), .io_rdata(io.io_rdata), .io_rack(io.io_rack));
  initial begin
    b2.io_addr = 0; b2.io_wdata = 0; b2.io_wr = 0; b2.io_rd = 0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] dflt(input int i);
    return i == 13 ? DEV_ID : i == 14 ? REV_ID : CFG_DEFAULTS[i];
  endfunction
  task automatic conclude();
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] x, m);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a; avs_writedata <= d; avs_write <= wr; avs_read <= !wr;
    if (!wr) q.push_back({x, m});
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      fail_count++;
      $display("[FAIL] %0t bus wait timed out", $time);
    end
    rd = avs_readdata;
    avs_read <= 0; avs_write <= 0;
  endtask
  // Polls busy so the next check sees a settled status
  task automatic op(input logic [1:0] o, input logic [3:0] i, input logic [7:0] d);
    av(1, AV_CMD, {8'h00, d, 4'h0, i, 6'h00, o}, 0, 0);
    repeat (20) begin
      av(0, AV_STATUS, 0, 0, 0);
      if (rd[0] === 1'b0) break;
    end
  endtask
  task automatic rdchk(input logic [3:0] i, input logic [7:0] x, input logic [2:0] st);
    op(OP_READ, i, 8'h00);
    av(0, AV_STATUS, 0, {16'h0, x, 5'h0, st}, st[2] ? 32'h6 : 32'hFF06);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w2(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    b2.io_addr <= a; b2.io_wdata <= d; b2.io_wr <= 1;
  endtask
  task automatic end2(input logic x);
    @(posedge clk);
    b2.io_wr <= 0;
    @(posedge clk);
    #1 comparisons++;
    if (act2 !== x) begin
      fail_count++;
      $display("[FAIL] %0t mode flag %b", $time, act2);
    end
  endtask
  always @(posedge clk) if (avs_read && avs_waitrequest === 1'b0) begin
    e = q.pop_front();
    comparisons++;
    if ((avs_readdata & e[31:0]) !== e[63:32]) begin
      fail_count++;
      $display("[FAIL] %0t status %h expected %h", $time, avs_readdata, e[63:32]);
    end
  end
  // Pulses stand one cycle, so each is counted once
  always @(posedge clk) begin
    if (abort2 === 1'b1) n_abort++;
    if (ref2 === 1'b1) n_ref++;
  end
  initial begin
    #200000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1; hrst_n <= 1; por_n <= 1;
    op(OP_ENTER, 0, 0);
    for (int i = 0; i < 16; i++) rdchk(4'(i), dflt(i), 3'b010);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      mem[i] = (i == 1) ? (rnd[7:0] | 8'h80) : rnd[7:0];
      op(OP_WRITE, 4'(i), mem[i]);
      if (!CFG_WR_MASK[i]) mem[i] = (i == 13 || i == 14) ? dflt(i) : 8'h00;
    end
    for (int i = 0; i < 16; i++) rdchk(4'(i), mem[i], 3'b010);
    op(OP_EXIT, 0, 0);
    rdchk(0, 0, 3'b100);
    @(posedge clk) hrst_n <= 0;
    @(posedge clk) hrst_n <= 1;
    op(OP_ENTER, 0, 0);
    rdchk(2, mem[2], 3'b010);
    op(OP_WRITE, 1, mem[1] & 8'h7F);
    rdchk(0, 8'h00, 3'b010);
    @(posedge clk) hrst_n <= 0;
    @(posedge clk) hrst_n <= 1;
    op(OP_ENTER, 0, 0);
    rdchk(1, mem[1], 3'b010);
    @(posedge clk) por_n <= 0;
    @(posedge clk) por_n <= 1;
    op(OP_ENTER, 0, 0);
    rdchk(0, CFG_DEFAULTS[0], 3'b010);
    w2(IDX_PORT, 8'h00); w2(DATA_PORT, 8'hC3);
    end2(1'b0);
    chk(regs2[7:0], CFG_DEFAULTS[0]);
    w2(IDX_PORT, KEY_ALT); w2(DATA_PORT, 8'h00); w2(IDX_PORT, KEY_ALT);
    end2(1'b0);
    chk(8'(n_abort), 8'h01);
    w2(IDX_PORT, KEY_STD); w2(IDX_PORT, KEY_STD);
    end2(1'b0);
    w2(IDX_PORT, KEY_ALT); w2(IDX_PORT, KEY_ALT);
    end2(1'b1);
    chk(8'(n_abort), 8'h02);
    chk({7'h0, open2}, 8'h01);
    w2(IDX_PORT, 8'h01); w2(DATA_PORT, 8'h1F); w2(DATA_PORT, 8'h77);
    end2(1'b1);
    chk(regs2[15:8], 8'h1F);
    chk({4'h0, idx2}, 8'h01);
    chk({7'h0, open2}, 8'h00);
    chk(8'(n_ref), 8'h01);
    w2(IDX_PORT, EXIT_KEY);
    end2(1'b0);
    conclude();
  end
endmodule // config_mode_register_access_tb

`default_nettype wire
